// >>> rtl/lcb_defs.svh
// Purpose: constants for the line channel control bank
// Assumes: classic wishbone, 32-bit data, one register per aligned word
// Notes: register index is the printed offset; byte address is index times four
`ifndef LCB_DEFS_SVH
`define LCB_DEFS_SVH

`define LCB_NCH            8
`define LCB_IDX_W          5
`define LCB_ADR_LSB        2
`define LCB_REG_RST        8'h00
`define LCB_RD_ZERO        32'h0000_0000

// primary bank
`define LCB_IDX_CRIT_SEL   5'h0d
`define LCB_IDX_GLOBAL_CFG 5'h0f
`define LCB_IDX_TX_OUT_DIS 5'h12
`define LCB_IDX_AIS_STAT   5'h13
`define LCB_IDX_AIS_IE     5'h14
`define LCB_IDX_AIS_FLAG   5'h15
`define LCB_IDX_IRQ_SETUP  5'h1e
// every bank
`define LCB_IDX_BANK_PTR   5'h1f
// secondary bank
`define LCB_IDX_RAIL_MODE  5'h00
`define LCB_IDX_LINE_CODE  5'h01
`define LCB_IDX_RX_PD      5'h03
`define LCB_IDX_TX_PD      5'h04
`define LCB_IDX_EXZ_EN     5'h05
`define LCB_IDX_CV_OFF     5'h06

// bank pointer values
`define LCB_BANK_PRIMARY   8'h00
`define LCB_BANK_SECONDARY 8'haa
`define LCB_BANK_INDIV     8'h01
`define LCB_BANK_BERT      8'h02

// field positions
`define LCB_GC_CODE_BIT    4
`define LCB_CWE_BIT        0

`endif

// >>> rtl/lcb_pkg.sv
// Purpose: types for the line channel control bank
// Assumes: eight channels
// Notes: vectors are indexed by channel, bit 0 is channel 1
package lcb_pkg;

   // five selections, so the code needs three bits
   typedef enum logic [2:0] {
      LCB_BANK_SEL_PRIMARY,
      LCB_BANK_SEL_SECONDARY,
      LCB_BANK_SEL_INDIV,
      LCB_BANK_SEL_BERT,
      LCB_BANK_SEL_NONE
   } lcb_bank_t;

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } lcb_wb_req_t;

   typedef struct packed {
      logic [7:0] tx_hiz;
      logic [7:0] single_rail;
      logic [7:0] ami;
      logic [7:0] rx_pd;
      logic [7:0] tx_pd;
      logic [7:0] exz_en;
      logic [7:0] cv_en;
      logic [7:0] crit_ets;
      logic [7:0] crit_t1;
   } lcb_ctrl_t;

endpackage

// >>> rtl/lcb_bank.sv
// Purpose: per-channel control and alarm status bank of an eight-channel line interface
// Assumes: ais_detect and e1_mode come from logic on clock; output_enable is an async pin
// Notes: answers every access one cycle after it is taken; unmapped reads give zero
//
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "lcb_defs.svh"

module lcb_bank (
   // clock and reset
   input  wire logic                clock,
   input  wire logic                rst_n,
   // wishbone slave
   input  wire lcb_pkg::lcb_wb_req_t wb_req,
   output logic                     wb_ack,
   output logic [31:0]              wb_dat_o,
   // line side
   input  wire logic                output_enable,
   input  wire logic [7:0]          ais_detect,
   input  wire logic [7:0]          e1_mode,
   output lcb_pkg::lcb_ctrl_t       ctrl,
   output lcb_pkg::lcb_bank_t       bank_sel,
   output logic                     irq
);

   function automatic logic reg_hit(input logic [7:0] bank, input logic [`LCB_IDX_W-1:0] idx,
                                    input logic [7:0] want_bank, input logic [`LCB_IDX_W-1:0] want_idx);
      reg_hit = (bank == want_bank) && (idx == want_idx);
   endfunction

   // software registers
   logic [7:0] crit_sel_r,  crit_sel_nxt;
   logic       gc_code_r,   gc_code_nxt;
   logic [7:0] out_dis_r,   out_dis_nxt;
   logic [7:0] ais_ie_r,    ais_ie_nxt;
   logic [7:0] ais_flag_r,  ais_flag_nxt;
   logic       cwe_r,       cwe_nxt;
   logic [7:0] bank_ptr_r,  bank_ptr_nxt;
   logic [7:0] rail_r,      rail_nxt;
   logic [7:0] lcode_r,     lcode_nxt;
   logic [7:0] rx_pd_r,     rx_pd_nxt;
   logic [7:0] tx_pd_r,     tx_pd_nxt;
   logic [7:0] exz_r,       exz_nxt;
   logic [7:0] cv_off_r,    cv_off_nxt;
   // bus answer
   logic        ack_r,      ack_nxt;
   logic [31:0] rdat_r,     rdat_nxt;
   // line status
   logic [7:0] ais_r,       ais_nxt;
   logic [7:0] ais_prev_r,  ais_prev_nxt;
   logic [2:0] oe_sync_r,   oe_sync_nxt;
   logic       oe_ok_r,     oe_ok_nxt;
   lcb_pkg::lcb_ctrl_t ctrl_r, ctrl_nxt;
   lcb_pkg::lcb_bank_t bank_r, bank_nxt;
   logic       irq_r,       irq_nxt;

   logic                  take;
   logic                  wr;
   logic                  rd;
   logic [`LCB_IDX_W-1:0] idx;
   logic [7:0]            wbyte;
   logic [7:0]            ais_edge;
   logic [7:0]            flag_clr;
   logic [7:0]            ami_eff;
   logic [7:0]            rbyte;
   logic                  mapped;

   assign take     = wb_req.cyc && wb_req.stb && !ack_r;
   assign wr       = take && wb_req.we && wb_req.sel[0];
   assign rd       = take && !wb_req.we;
   assign idx      = wb_req.adr[`LCB_ADR_LSB +: `LCB_IDX_W];
   assign wbyte    = wb_req.dat[7:0];
   assign ais_edge = ais_r ^ ais_prev_r;

   // register file writes and read mux
   always_comb begin
      crit_sel_nxt = crit_sel_r;
      gc_code_nxt  = gc_code_r;
      out_dis_nxt  = out_dis_r;
      ais_ie_nxt   = ais_ie_r;
      cwe_nxt      = cwe_r;
      bank_ptr_nxt = bank_ptr_r;
      rail_nxt     = rail_r;
      lcode_nxt    = lcode_r;
      rx_pd_nxt    = rx_pd_r;
      tx_pd_nxt    = tx_pd_r;
      exz_nxt      = exz_r;
      cv_off_nxt   = cv_off_r;
      flag_clr     = `LCB_REG_RST;
      rbyte        = `LCB_REG_RST;
      mapped       = 1'b1;
      // the pointer stays reachable whatever bank is selected, or software could lock itself out
      if (idx == `LCB_IDX_BANK_PTR) begin
         rbyte = bank_ptr_r;
         if (wr) begin
            bank_ptr_nxt = wbyte;
         end
      end else if (reg_hit(bank_ptr_r, idx, `LCB_BANK_PRIMARY, `LCB_IDX_CRIT_SEL)) begin
         rbyte = crit_sel_r;
         if (wr) begin
            crit_sel_nxt = wbyte;
         end
      end else if (reg_hit(bank_ptr_r, idx, `LCB_BANK_PRIMARY, `LCB_IDX_GLOBAL_CFG)) begin
         rbyte[`LCB_GC_CODE_BIT] = gc_code_r;
         if (wr) begin
            gc_code_nxt = wbyte[`LCB_GC_CODE_BIT];
         end
      end else if (reg_hit(bank_ptr_r, idx, `LCB_BANK_PRIMARY, `LCB_IDX_TX_OUT_DIS)) begin
         rbyte = out_dis_r;
         if (wr) begin
            out_dis_nxt = wbyte;
         end
      end else if (reg_hit(bank_ptr_r, idx, `LCB_BANK_PRIMARY, `LCB_IDX_AIS_STAT)) begin
         rbyte = ais_r;
      end else if (reg_hit(bank_ptr_r, idx, `LCB_BANK_PRIMARY, `LCB_IDX_AIS_IE)) begin
         rbyte = ais_ie_r;
         if (wr) begin
            ais_ie_nxt = wbyte;
         end
      end else if (reg_hit(bank_ptr_r, idx, `LCB_BANK_PRIMARY, `LCB_IDX_AIS_FLAG)) begin
         rbyte = ais_flag_r;
         if (rd && !cwe_r) begin
            flag_clr = ais_flag_r;
         end else if (wr && cwe_r) begin
            flag_clr = wbyte;
         end
      end else if (reg_hit(bank_ptr_r, idx, `LCB_BANK_PRIMARY, `LCB_IDX_IRQ_SETUP)) begin
         rbyte[`LCB_CWE_BIT] = cwe_r;
         if (wr) begin
            cwe_nxt = wbyte[`LCB_CWE_BIT];
         end
      end else if (reg_hit(bank_ptr_r, idx, `LCB_BANK_SECONDARY, `LCB_IDX_RAIL_MODE)) begin
         rbyte = rail_r;
         if (wr) begin
            rail_nxt = wbyte;
         end
      end else if (reg_hit(bank_ptr_r, idx, `LCB_BANK_SECONDARY, `LCB_IDX_LINE_CODE)) begin
         rbyte = lcode_r;
         if (wr) begin
            lcode_nxt = wbyte;
         end
      end else if (reg_hit(bank_ptr_r, idx, `LCB_BANK_SECONDARY, `LCB_IDX_RX_PD)) begin
         rbyte = rx_pd_r;
         if (wr) begin
            rx_pd_nxt = wbyte;
         end
      end else if (reg_hit(bank_ptr_r, idx, `LCB_BANK_SECONDARY, `LCB_IDX_TX_PD)) begin
         rbyte = tx_pd_r;
         if (wr) begin
            tx_pd_nxt = wbyte;
         end
      end else if (reg_hit(bank_ptr_r, idx, `LCB_BANK_SECONDARY, `LCB_IDX_EXZ_EN)) begin
         rbyte = exz_r;
         if (wr) begin
            exz_nxt = wbyte;
         end
      end else if (reg_hit(bank_ptr_r, idx, `LCB_BANK_SECONDARY, `LCB_IDX_CV_OFF)) begin
         rbyte = cv_off_r;
         if (wr) begin
            cv_off_nxt = wbyte;
         end
      end else begin
         mapped = 1'b0;
      end
   end

   // bus answer: one wait-free cycle, unmapped reads return zero and writes are dropped
   always_comb begin
      ack_nxt  = take;
      rdat_nxt = rdat_r;
      if (rd) begin
         rdat_nxt = mapped ? {24'h00_0000, rbyte} : `LCB_RD_ZERO;
      end
   end

   // alarm status and change flags; a new edge wins over a clear in the same cycle
   always_comb begin
      ais_nxt      = ais_detect;
      ais_prev_nxt = ais_r;
      ais_flag_nxt = (ais_flag_r & ~flag_clr) | ais_edge;
      irq_nxt      = |(ais_flag_r & ais_ie_r);
   end

   // output-enable pin filter: a change counts once the second and third stages agree
   always_comb begin
      oe_sync_nxt = {oe_sync_r[1:0], output_enable};
      oe_ok_nxt   = oe_ok_r;
      if (oe_sync_r[1] == oe_sync_r[2]) begin
         oe_ok_nxt = oe_sync_r[2];
      end
   end

   // bank decode
   always_comb begin
      case (bank_ptr_r)
         `LCB_BANK_PRIMARY:   bank_nxt = lcb_pkg::LCB_BANK_SEL_PRIMARY;
         `LCB_BANK_SECONDARY: bank_nxt = lcb_pkg::LCB_BANK_SEL_SECONDARY;
         `LCB_BANK_INDIV:     bank_nxt = lcb_pkg::LCB_BANK_SEL_INDIV;
         `LCB_BANK_BERT:      bank_nxt = lcb_pkg::LCB_BANK_SEL_BERT;
         default:             bank_nxt = lcb_pkg::LCB_BANK_SEL_NONE;
      endcase
   end

   // per-channel line controls
   always_comb begin
      ami_eff              = gc_code_r ? 8'hff : lcode_r;
      ctrl_nxt.tx_hiz      = out_dis_r | {8{!oe_ok_r}};
      ctrl_nxt.single_rail = rail_r;
      ctrl_nxt.ami         = ami_eff;
      ctrl_nxt.rx_pd       = rx_pd_r;
      ctrl_nxt.tx_pd       = tx_pd_r;
      ctrl_nxt.exz_en      = exz_r & rail_r & ~ami_eff;
      // hdb3 only exists on e1 lines; under the global code bit the off bits are ignored
      ctrl_nxt.cv_en       = ~(gc_code_r ? 8'h00 : cv_off_r) & ~ami_eff & e1_mode;
      ctrl_nxt.crit_ets    = crit_sel_r & e1_mode;
      ctrl_nxt.crit_t1     = ~e1_mode;
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         crit_sel_r <= `LCB_REG_RST;
         gc_code_r  <= 1'b0;
         out_dis_r  <= `LCB_REG_RST;
         ais_ie_r   <= `LCB_REG_RST;
         ais_flag_r <= `LCB_REG_RST;
         cwe_r      <= 1'b0;
         bank_ptr_r <= `LCB_REG_RST;
         rail_r     <= `LCB_REG_RST;
         lcode_r    <= `LCB_REG_RST;
         rx_pd_r    <= `LCB_REG_RST;
         tx_pd_r    <= `LCB_REG_RST;
         exz_r      <= `LCB_REG_RST;
         cv_off_r   <= `LCB_REG_RST;
         ack_r      <= 1'b0;
         rdat_r     <= `LCB_RD_ZERO;
         ais_r      <= `LCB_REG_RST;
         ais_prev_r <= `LCB_REG_RST;
         oe_sync_r  <= 3'h0;
         oe_ok_r    <= 1'b0;
         ctrl_r     <= '0;
         bank_r     <= lcb_pkg::LCB_BANK_SEL_PRIMARY;
         irq_r      <= 1'b0;
      end else begin
         crit_sel_r <= crit_sel_nxt;
         gc_code_r  <= gc_code_nxt;
         out_dis_r  <= out_dis_nxt;
         ais_ie_r   <= ais_ie_nxt;
         ais_flag_r <= ais_flag_nxt;
         cwe_r      <= cwe_nxt;
         bank_ptr_r <= bank_ptr_nxt;
         rail_r     <= rail_nxt;
         lcode_r    <= lcode_nxt;
         rx_pd_r    <= rx_pd_nxt;
         tx_pd_r    <= tx_pd_nxt;
         exz_r      <= exz_nxt;
         cv_off_r   <= cv_off_nxt;
         ack_r      <= ack_nxt;
         rdat_r     <= rdat_nxt;
         ais_r      <= ais_nxt;
         ais_prev_r <= ais_prev_nxt;
         oe_sync_r  <= oe_sync_nxt;
         oe_ok_r    <= oe_ok_nxt;
         ctrl_r     <= ctrl_nxt;
         bank_r     <= bank_nxt;
         irq_r      <= irq_nxt;
      end
   end

   assign wb_ack   = ack_r;
   assign wb_dat_o = rdat_r;
   assign ctrl     = ctrl_r;
   assign bank_sel = bank_r;
   assign irq      = irq_r;

   a_oe_override: assert property (@(posedge clock) disable iff (!rst_n)
      !oe_ok_r |=> (ctrl_r.tx_hiz == 8'hff)) else $error("pin low did not force all outputs off");

   a_tx_hiz_bits: assert property (@(posedge clock) disable iff (!rst_n)
      ##1 ((ctrl_r.tx_hiz & $past(out_dis_r)) == $past(out_dis_r))) else $error("disabled channel still driving");

   a_flag_on_edge: assert property (@(posedge clock) disable iff (!rst_n)
      ##1 ((ais_flag_r & $past(ais_edge)) == $past(ais_edge))) else $error("alarm change not latched");

   a_read_clears: assert property (@(posedge clock) disable iff (!rst_n)
      (rd && !cwe_r && ais_edge == 8'h00 && reg_hit(bank_ptr_r, idx, `LCB_BANK_PRIMARY, `LCB_IDX_AIS_FLAG))
      |=> (ais_flag_r == 8'h00)) else $error("read did not clear flags");

   a_cwe_hold: assert property (@(posedge clock) disable iff (!rst_n)
      (cwe_r && !wr && ais_edge == 8'h00) |=> $stable(ais_flag_r)) else $error("flag cleared without a write");

   a_irq_quiet: assert property (@(posedge clock) disable iff (!rst_n)
      ((ais_flag_r & ais_ie_r) == 8'h00) [*2] |-> !irq_r) else $error("interrupt without an enabled flag");

   a_irq_raise: assert property (@(posedge clock) disable iff (!rst_n)
      ((ais_flag_r & ais_ie_r) != 8'h00) |=> irq_r) else $error("enabled flag gave no interrupt");

   a_code_forces: assert property (@(posedge clock) disable iff (!rst_n)
      gc_code_r |=> (ctrl_r.ami == 8'hff && ctrl_r.cv_en == 8'h00)) else $error("global code did not force ami");

   a_exz_gate: assert property (@(posedge clock) disable iff (!rst_n)
      (ctrl_r.exz_en & ~(ctrl_r.single_rail & ~ctrl_r.ami)) == 8'h00) else $error("excess zero outside single-rail hdb3");

   a_ack_pulse: assert property (@(posedge clock) disable iff (!rst_n)
      take |=> (ack_r ##1 !ack_r)) else $error("ack not a one-cycle answer");

endmodule

// >>> dv/lcb_host.sv
// Purpose: host processor model driving the bank's wishbone port
// Assumes: classic single cycle, answer waited for without a fixed count
// Notes: the bench's timeout is the only thing that ends a hung wait
`timescale 1ns/1ps
module lcb_host (
   // bus
   input  wire logic              clock,
   output lcb_pkg::lcb_wb_req_t   wb_req,
   input  wire logic              wb_ack,
   input  wire logic [31:0]       wb_dat_o
);
   initial wb_req = '0;

   // request held until ack is sampled and dropped at that edge; the next call waits an edge, so cyc stays low one cycle
   task automatic xfer(input logic we, input logic [4:0] idx, input logic [7:0] d, output logic [31:0] q);
      @(posedge clock);
      wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {1'b0, idx, 2'b00}, sel: 4'hf, dat: {24'h0, d}};
      do @(posedge clock); while (wb_ack !== 1'b1);
      q = wb_dat_o;
      wb_req <= '0;
   endtask
endmodule

// >>> dv/liu_channel_control_bank_test.sv
// Purpose: self-checking bench for the channel control bank
// Assumes: host model issues every bus cycle
// Notes: ctrl outputs are compared a few edges after the write that moves them
`timescale 1ns/1ps
`include "lcb_defs.svh"
module liu_channel_control_bank_test;
   logic                  clock = 1'b0;
   logic                  rst_n = 1'b0;
   lcb_pkg::lcb_wb_req_t  wb_req;
   logic                  wb_ack;
   logic [31:0]           wb_dat_o;
   logic                  output_enable = 1'b1;
   logic [7:0]            ais_detect = 8'h00;
   logic [7:0]            e1_mode = 8'hf0;
   lcb_pkg::lcb_ctrl_t    ctrl;
   lcb_pkg::lcb_bank_t    bank_sel;
   logic                  irq;
   int                    n_fail = 0;
   int                    n_checks = 0;
   int                    cyc_n = 0;

   always #4 clock = ~clock;

   lcb_bank lcb_bank_i (.clock(clock), .rst_n(rst_n), .wb_req(wb_req), .wb_ack(wb_ack), .wb_dat_o(wb_dat_o),
      .output_enable(output_enable), .ais_detect(ais_detect), .e1_mode(e1_mode), .ctrl(ctrl),
      .bank_sel(bank_sel), .irq(irq));
   lcb_host lcb_host_i (.clock(clock), .wb_req(wb_req), .wb_ack(wb_ack), .wb_dat_o(wb_dat_o));

   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // a hang counts as a mismatch and closes the run
   always @(posedge clock) begin
      cyc_n <= cyc_n + 1;
      if (cyc_n == 20000) begin
         n_fail++;
         results();
      end
   end

   task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", n, exp, seen);
      end
   endtask

   task automatic wr(input logic [4:0] i, input logic [7:0] d);
      logic [31:0] q;
      lcb_host_i.xfer(1'b1, i, d, q);
   endtask

   task automatic rd(input logic [4:0] i, input logic [7:0] e);
      logic [31:0] q;
      lcb_host_i.xfer(1'b0, i, 8'h00, q);
      chk($sformatf("reg %h", i), q, {24'h0, e});
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clock);
   endtask

   task automatic t_reset();
      logic [4:0] idx [8] = '{5'h0d, 5'h0f, 5'h12, 5'h13, 5'h14, 5'h15, 5'h1e, 5'h1f};
      chk("bank_sel", 32'(bank_sel), 32'(lcb_pkg::LCB_BANK_SEL_PRIMARY));
      foreach (idx[k]) rd(idx[k], `LCB_REG_RST);
      // unmapped index: write dropped, read gives zero
      wr(5'h02, 8'hff);
      rd(5'h02, 8'h00);
   endtask

   task automatic t_bank();
      logic [7:0] ptr [4] = '{8'haa, 8'h01, 8'h02, 8'h00};
      lcb_pkg::lcb_bank_t exp [4] = '{lcb_pkg::LCB_BANK_SEL_SECONDARY, lcb_pkg::LCB_BANK_SEL_INDIV,
                                      lcb_pkg::LCB_BANK_SEL_BERT, lcb_pkg::LCB_BANK_SEL_PRIMARY};
      foreach (ptr[k]) begin
         wr(`LCB_IDX_BANK_PTR, ptr[k]);
         settle(2);
         chk("bank_sel", 32'(bank_sel), 32'(exp[k]));
         rd(`LCB_IDX_BANK_PTR, ptr[k]);
      end
   endtask

   task automatic t_second();
      logic [4:0] idx [6] = '{5'h00, 5'h01, 5'h03, 5'h04, 5'h05, 5'h06};
      logic [7:0] val [6] = '{8'h0f, 8'h33, 8'ha5, 8'h5a, 8'hff, 8'h0f};
      wr(`LCB_IDX_BANK_PTR, `LCB_BANK_SECONDARY);
      foreach (idx[k]) wr(idx[k], val[k]);
      foreach (idx[k]) rd(idx[k], val[k]);
      settle(2);
      chk("single_rail", 32'(ctrl.single_rail), 32'h0f);
      chk("ami", 32'(ctrl.ami), 32'h33);
      chk("rx_pd", 32'(ctrl.rx_pd), 32'ha5);
      chk("tx_pd", 32'(ctrl.tx_pd), 32'h5a);
      // only single-rail, non-AMI channels keep excess zero detection
      chk("exz_en", 32'(ctrl.exz_en), 32'h0c);
      // only E1 channels without AMI and not switched off keep violation detection
      chk("cv_en", 32'(ctrl.cv_en), 32'hc0);
   endtask

   task automatic t_code();
      wr(`LCB_IDX_BANK_PTR, `LCB_BANK_PRIMARY);
      wr(`LCB_IDX_GLOBAL_CFG, 8'hff);
      rd(`LCB_IDX_GLOBAL_CFG, 8'h10);
      settle(2);
      chk("ami", 32'(ctrl.ami), 32'hff);
      chk("cv_en", 32'(ctrl.cv_en), 32'h00);
      chk("exz_en", 32'(ctrl.exz_en), 32'h00);
      wr(`LCB_IDX_GLOBAL_CFG, 8'h00);
      settle(2);
      chk("ami", 32'(ctrl.ami), 32'h33);
      chk("cv_en", 32'(ctrl.cv_en), 32'hc0);
   endtask

   task automatic t_oe();
      wr(`LCB_IDX_TX_OUT_DIS, 8'h81);
      rd(`LCB_IDX_TX_OUT_DIS, 8'h81);
      settle(2);
      chk("tx_hiz", 32'(ctrl.tx_hiz), 32'h81);
      output_enable <= 1'b0;
      settle(12);
      chk("tx_hiz", 32'(ctrl.tx_hiz), 32'hff);
      output_enable <= 1'b1;
      settle(12);
      chk("tx_hiz", 32'(ctrl.tx_hiz), 32'h81);
   endtask

   task automatic t_crit();
      wr(`LCB_IDX_CRIT_SEL, 8'h3c);
      rd(`LCB_IDX_CRIT_SEL, 8'h3c);
      settle(2);
      chk("crit_ets", 32'(ctrl.crit_ets), 32'h30);
      chk("crit_t1", 32'(ctrl.crit_t1), 32'h0f);
   endtask

   task automatic t_ais();
      wr(`LCB_IDX_AIS_IE, 8'h03);
      ais_detect <= 8'h05;
      settle(5);
      rd(`LCB_IDX_AIS_STAT, 8'h05);
      wr(`LCB_IDX_AIS_STAT, 8'hff);
      rd(`LCB_IDX_AIS_STAT, 8'h05);
      chk("irq", 32'(irq), 32'h1);
      // read returns the flags and clears them at the same edge
      rd(`LCB_IDX_AIS_FLAG, 8'h05);
      rd(`LCB_IDX_AIS_FLAG, 8'h00);
      settle(3);
      chk("irq", 32'(irq), 32'h0);
      ais_detect <= 8'h04;
      settle(5);
      chk("irq", 32'(irq), 32'h1);
      wr(`LCB_IDX_IRQ_SETUP, 8'h01);
      rd(`LCB_IDX_AIS_FLAG, 8'h01);
      rd(`LCB_IDX_AIS_FLAG, 8'h01);
      wr(`LCB_IDX_AIS_FLAG, 8'h00);
      rd(`LCB_IDX_AIS_FLAG, 8'h01);
      wr(`LCB_IDX_AIS_FLAG, 8'h01);
      rd(`LCB_IDX_AIS_FLAG, 8'h00);
      // a change on a masked channel latches but keeps the interrupt low
      ais_detect <= 8'h00;
      settle(5);
      rd(`LCB_IDX_AIS_FLAG, 8'h04);
      chk("irq", 32'(irq), 32'h0);
   endtask

   initial begin
      settle(4);
      rst_n <= 1'b1;
      settle(12);
      t_reset();
      t_bank();
      t_second();
      t_code();
      t_oe();
      t_crit();
      t_ais();
      results();
   end
endmodule
